// [src/swe_wakeup.sv]
// always-on sleep wake-up event logic with retained scratch and pin state
`timescale 1ns/1ns
// ============================================================
// What this block does
// - leave sleep on temp, supply, restore, rtc, irq pins, rx edge, reset
// - clearing enable bit 3 disables supply-sense wake
// - supply restoration always wakes, sets flag bit 7, power vector
// - rail-source bit 6 shows main supply when rail switches
// - rtc interval wakes, sets flag bit 2, rtc vector, maskable
// - irq pin zero wakes when select bit 0 set, edge chosen
// - irq pin one wakes when config bits 3:1 are 11x
// - pin wakes leave pending flags unchanged, raise neither power nor rtc vector
// - rx select 11: any rx edge wakes and sets rx flag
// - external reset low in sleep always wakes, to battery run unless main supply is ok (then normal run)
// - lcd stays controllable in sleep, lcd memory kept
// - four scratch pad registers kept through sleep
// - pins are inputs in sleep, pull-ups individually disableable
// - wake from sleep restarts core at power-on vector
module swe_wakeup #(
    parameter int PIN_COUNT = 24
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic                  clkEn,
    input  wire swe_pkg::swe_config_s  cfg,
    input  wire swe_pkg::swe_events_s  events,
    input  wire logic                  extIrqPinZero,
    input  wire logic                  extIrqPinOne,
    input  wire logic                  secondSerialRxLine,
    input  wire logic                  extResetPin_n,
    input  wire logic                  sleepRequest,
    input  wire swe_pkg::swe_flags_s   flagClear,
    input  wire logic                  scratchWrite,
    input  wire logic [1:0]            scratchIndex,
    input  wire logic [7:0]            scratchData,
    input  wire logic                  lcdEnableIn,
    input  wire logic [PIN_COUNT-1:0]  pinOutValue,
    input  wire logic [PIN_COUNT-1:0]  pinOutEnable,
    input  wire logic [PIN_COUNT-1:0]  pullupEnableReg,
    output logic                       wakeRequest,
    output swe_pkg::swe_power_state_e  powerState,
    output swe_pkg::swe_flags_s        flags,
    output logic                       railSourceBit,
    output logic                       powerMgmtVector,
    output logic                       rtcVector,
    output logic                       coreResetToVector,
    output logic [7:0]                 scratchRead,
    output logic                       lcdEnable,
    output logic [PIN_COUNT-1:0]       pinOut,
    output logic [PIN_COUNT-1:0]       pinOe,
    output logic [PIN_COUNT-1:0]       pullupOn
);
    // refused at elaboration: the pin vectors need at least one bit
    if (PIN_COUNT < 1) begin : pinCountCheck
        $error("PIN_COUNT must be at least one");
    end

    // ============================================================
    // reset release
    logic rstMeta, rstSync;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // ============================================================
    // edge detection on pins
    logic irqZeroLast, irqOneLast, rxLast, supplyLast;
    logic next_irqZeroLast, next_irqOneLast, next_rxLast, next_supplyLast;
    logic irqZeroEdge, irqOneEdge, rxEdge, supplyRise, irqOneSel;

    always_comb begin
        next_irqZeroLast = extIrqPinZero;
        next_irqOneLast  = extIrqPinOne;
        next_rxLast      = secondSerialRxLine;
        next_supplyLast  = events.mainSupplyOk;
        // edge chosen: 1 falling, 0 low level
        irqZeroEdge = cfg.irqZeroEdgeSelect ? (irqZeroLast & ~extIrqPinZero) : ~extIrqPinZero;
        irqOneEdge  = cfg.irqOneEdgeSelect ? (irqOneLast & ~extIrqPinOne) : ~extIrqPinOne;
        rxEdge      = rxLast ^ secondSerialRxLine;
        supplyRise  = ~supplyLast & events.mainSupplyOk;
        // select bits 3:2 equal 11, bit 1 don't care
        irqOneSel   = cfg.irqPinConfigReg[swe_pkg::IRQ_ONE_SEL_HI:swe_pkg::IRQ_ONE_SEL_LO]
                      == swe_pkg::IRQ_ONE_ON;
    end

    always_ff @(posedge ref_clk or negedge rstSync) begin
        if (!rstSync) begin
            irqZeroLast <= 1'b1;
            irqOneLast  <= 1'b1;
            rxLast      <= 1'b1;
            supplyLast  <= 1'b0;
        end else if (clkEn) begin
            irqZeroLast <= next_irqZeroLast;
            irqOneLast  <= next_irqOneLast;
            rxLast      <= next_rxLast;
            supplyLast  <= next_supplyLast;
        end
    end

    // ============================================================
    // sticky flags: a set in the clear cycle wins
    swe_pkg::swe_flags_s set, next_flags;
    logic next_railSourceBit;
    always_comb begin
        // temperature pending gated by sleep measuring
        set.tempPending           = events.tempChange & cfg.tempMeasureInSleep;
        set.supplySenseChangeFlag = events.supplySenseChange;
        set.supplyRestoredFlag    = supplyRise;
        set.rtcIntervalFlag       = events.rtcInterval;
        set.rtcAlarmFlag          = events.rtcAlarm & cfg.alarmFieldEnables;
        set.rxEdgeFlag            = rxEdge &
                                    (cfg.rxWakeSelect == swe_pkg::RX_WAKE_ON);
        // pin wakes held apart from the pending flags of the core
        set.irqZeroWake           = irqZeroEdge & cfg.irqPinConfigReg[swe_pkg::IRQ_ZERO_SEL_BIT];
        set.irqOneWake            = irqOneEdge & irqOneSel;
        next_flags = (flags & ~flagClear) | set;
        // rail source follows the main supply
        next_railSourceBit = events.mainSupplyOk;
    end

    // ============================================================
    // wake request and power state
    logic wakeAny;
    swe_pkg::swe_power_state_e next_powerState;
    logic next_wakeRequest, next_pmVec, next_rtcVec, next_coreReset;
    always_comb begin
        // or of enabled and nonmaskable sources
        // supply-sense masked by enable bit 3
        wakeAny = (flags.tempPending & cfg.tempWakeEnable)
                | (flags.supplySenseChangeFlag &
                   cfg.powerIrqEnableReg[swe_pkg::SUPPLY_SENSE_BIT])
                | flags.supplyRestoredFlag
                | (flags.rtcIntervalFlag & cfg.rtcIntervalEnable)
                | flags.rtcAlarmFlag
                | flags.irqZeroWake | flags.irqOneWake | flags.rxEdgeFlag;
        next_wakeRequest = wakeAny;
        next_pmVec  = flags.supplySenseChangeFlag | flags.supplyRestoredFlag;
        next_rtcVec = flags.rtcIntervalFlag | flags.rtcAlarmFlag;
        next_coreReset  = 1'b0;
        next_powerState = powerState;
        case (powerState)
            swe_pkg::NORMAL_RUN_STATE: begin
                if (!events.mainSupplyOk) next_powerState = swe_pkg::BATTERY_RUN_STATE;
            end
            swe_pkg::BATTERY_RUN_STATE: begin
                if (events.mainSupplyOk) next_powerState = swe_pkg::NORMAL_RUN_STATE;
                else if (sleepRequest) next_powerState = swe_pkg::SLEEP_STATE;
            end
            swe_pkg::SLEEP_STATE: begin
                // reset pin low wakes to battery run, or to normal run if main supply is ok
                if (events.mainSupplyOk) begin
                    next_powerState = swe_pkg::NORMAL_RUN_STATE;
                    next_coreReset  = 1'b1;
                end else if (wakeAny || !extResetPin_n) begin
                    next_powerState = swe_pkg::BATTERY_RUN_STATE;
                    next_coreReset  = 1'b1;
                end
            end
            default: next_powerState = swe_pkg::BATTERY_RUN_STATE;
        endcase
    end

    // ============================================================
    // retained state: scratch, lcd, pins
    logic [7:0] scratch [swe_pkg::SCRATCH_COUNT];
    logic [7:0] next_scratchRead;
    logic       inSleep;
    always_comb begin
        inSleep = (next_powerState == swe_pkg::SLEEP_STATE);
        next_scratchRead = scratch[scratchIndex];
    end

    always_ff @(posedge ref_clk or negedge rstSync) begin
        if (!rstSync) begin
            flags             <= '0;
            railSourceBit     <= 1'b0;
            powerState        <= swe_pkg::BATTERY_RUN_STATE;
            wakeRequest       <= 1'b0;
            powerMgmtVector   <= 1'b0;
            rtcVector         <= 1'b0;
            coreResetToVector <= 1'b0;
            scratchRead       <= swe_pkg::REG_RESET;
            lcdEnable         <= 1'b0;
            pinOut            <= '0;
            pinOe             <= '0;
            pullupOn          <= '0;
            for (int i = 0; i < swe_pkg::SCRATCH_COUNT; i++) scratch[i] <= swe_pkg::REG_RESET;
        end else if (clkEn) begin
            flags             <= next_flags;
            railSourceBit     <= next_railSourceBit;
            powerState        <= next_powerState;
            wakeRequest       <= next_wakeRequest;
            powerMgmtVector   <= next_pmVec;
            rtcVector         <= next_rtcVec;
            coreResetToVector <= next_coreReset;
            scratchRead       <= next_scratchRead;
            // lcd control stays live, memory untouched by sleep
            lcdEnable         <= lcdEnableIn;
            // pins become inputs in sleep, pull-ups stay per pin
            pinOut            <= inSleep ? '0 : pinOutValue;
            pinOe             <= inSleep ? '0 : pinOutEnable;
            pullupOn          <= pullupEnableReg;
            // scratch only changes by core write or reset, never when entering or staying in sleep
            if (scratchWrite && !inSleep) scratch[scratchIndex] <= scratchData;
        end
    end

    // ============================================================
    // checks
    // restore always reaches the flag
    restore_flag_a: assert property (@(posedge ref_clk) disable iff (!rstSync)
        (clkEn && supplyRise) |=> flags.supplyRestoredFlag)
        else $error("supply restore did not set flag");
    sense_mask_a: assert property (@(posedge ref_clk) disable iff (!rstSync)
        (clkEn && flags == swe_pkg::swe_flags_s'{supplySenseChangeFlag: 1'b1, default: 1'b0} &&
         !cfg.powerIrqEnableReg[swe_pkg::SUPPLY_SENSE_BIT] && !cfg.tempWakeEnable)
        |=> !wakeRequest)
        else $error("masked supply-sense woke the block");
    reset_wake_a: assert property (@(posedge ref_clk) disable iff (!rstSync)
        (clkEn && powerState == swe_pkg::SLEEP_STATE && !extResetPin_n)
        |=> powerState != swe_pkg::SLEEP_STATE && coreResetToVector)
        else $error("reset pin did not wake from sleep");
    sleep_pins_a: assert property (@(posedge ref_clk) disable iff (!rstSync)
        (powerState == swe_pkg::SLEEP_STATE && $stable(powerState)) |-> pinOe == '0)
        else $error("pin driven during sleep");
    restart_pulse_a: assert property (@(posedge ref_clk) disable iff (!rstSync)
        (clkEn && coreResetToVector) |=> !coreResetToVector)
        else $error("restart pulse longer than one cycle");
    restore_wake_a: assert property (@(posedge ref_clk) disable iff (!rstSync)
        (clkEn && flags.supplyRestoredFlag) |=> wakeRequest)
        else $error("restore flag did not raise wake request");
    // selected rx edge sets its flag
    rx_edge_a: assert property (@(posedge ref_clk) disable iff (!rstSync)
        (clkEn && rxEdge && cfg.rxWakeSelect == swe_pkg::RX_WAKE_ON) |=> flags.rxEdgeFlag)
        else $error("rx edge did not set its flag");
endmodule // swe_wakeup

// [src/swe_pkg.sv]
// package for the sleep wake-up event logic: bit positions, reset values, carriers
package swe_pkg;
    // power management flag / enable bit positions
    localparam int SUPPLY_SENSE_BIT    = 3;
    localparam int SUPPLY_RESTORED_BIT = 7;
    // rtc config bit positions
    localparam int RTC_INTERVAL_BIT    = 2;
    localparam int RTC_ALARM_BIT       = 6;
    // peripheral config bit positions
    localparam int RX_EDGE_BIT         = 7;
    localparam int RAIL_SOURCE_BIT     = 6;
    // interrupt pin config
    localparam int IRQ_ZERO_SEL_BIT    = 0;
    localparam int IRQ_ONE_SEL_HI      = 3;
    localparam int IRQ_ONE_SEL_LO      = 2;
    localparam logic [1:0] RX_WAKE_ON  = 2'h3;
    localparam logic [1:0] IRQ_ONE_ON  = 2'h3;
    localparam logic [7:0] REG_RESET   = 8'h00;
    localparam int SCRATCH_COUNT       = 4;

    typedef enum logic [1:0] {
        NORMAL_RUN_STATE,
        BATTERY_RUN_STATE,
        SLEEP_STATE
    } swe_power_state_e;

    // configuration that software leaves in the always-on domain
    typedef struct packed {
        logic       tempWakeEnable;
        logic       tempMeasureInSleep;
        logic [7:0] powerIrqEnableReg;
        logic [7:0] irqPinConfigReg;
        logic       irqZeroEdgeSelect;
        logic       irqOneEdgeSelect;
        logic [1:0] rxWakeSelect;
        logic       rtcIntervalEnable;
        logic       alarmFieldEnables;
    } swe_config_s;

    // raw event inputs, one-cycle pulses except mainSupplyOk, which is a level
    typedef struct packed {
        logic tempChange;
        logic supplySenseChange;
        logic mainSupplyOk;
        logic rtcInterval;
        logic rtcAlarm;
    } swe_events_s;

    // sticky flags, set by hardware, cleared by software
    typedef struct packed {
        logic tempPending;
        logic supplySenseChangeFlag;
        logic supplyRestoredFlag;
        logic rtcIntervalFlag;
        logic rtcAlarmFlag;
        logic rxEdgeFlag;
        logic irqZeroWake;
        logic irqOneWake;
    } swe_flags_s;
endpackage

// [testbench/swe_soft_model.sv]
// software partner model: acknowledges wake flags, then asks for sleep
`timescale 1ns/1ns
module swe_soft_model (
    input  wire logic                ref_clk,
    input  wire logic                sleepCmd,
    input  wire swe_pkg::swe_flags_s flags,
    output swe_pkg::swe_flags_s      flagClear,
    output logic                     sleepRequest
);
    // ============================================================
    // sleep entry sequence, one process owns both outputs
    initial begin
        flagClear    = '0;
        sleepRequest = 1'b0;
        forever begin
            @(posedge ref_clk);
            if (sleepCmd) begin
                #1 flagClear = flags;
                @(posedge ref_clk);
                #1 flagClear = '0;
                sleepRequest = 1'b1;
                @(posedge ref_clk);
                #1 sleepRequest = 1'b0;
            end
        end
    end
endmodule // swe_soft_model

// [testbench/tb.sv]
// self-checking bench for the sleep wake-up event logic
`timescale 1ns/1ns
module tb;
    logic                      ref_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, sleepCmd = 1'b0;
    swe_pkg::swe_config_s      cfg = '0;
    swe_pkg::swe_events_s      events = '0;
    logic                      irq0 = 1'b1, irq1 = 1'b1, rxLine = 1'b1, extReset_n = 1'b1;
    logic                      scratchWrite = 1'b0, lcdEnableIn = 1'b1;
    logic [1:0]                scratchIndex = 2'h0;
    logic [7:0]                scratchData = 8'h00, scratchRead;
    logic [23:0]               pinOutValue = 24'hFFFFFF, pinOutEnable = 24'hFFFFFF;
    logic [23:0]               pullupEnableReg = 24'h5A5A5A, pinOut, pinOe, pullupOn;
    logic                      wakeRequest, railSourceBit, powerMgmtVector, rtcVector;
    logic                      coreResetToVector, lcdEnable, sleepRequest;
    swe_pkg::swe_power_state_e powerState;
    swe_pkg::swe_flags_s       flags, flagClear;
    int                        n_fail = 0, check_count = 0, vecCount = 0, waitCycles, v;
    // flag bit expected per source: temp, sense, interval, alarm, pin0, pin1, rx, reset
    localparam logic [7:0] WAKE_MASK [8] = '{8'h80, 8'h40, 8'h10, 8'h08, 8'h02, 8'h01,
                                             8'h04, 8'h00};

    swe_wakeup swe_wakeup_inst (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .cfg(cfg),
        .events(events), .extIrqPinZero(irq0), .extIrqPinOne(irq1),
        .secondSerialRxLine(rxLine), .extResetPin_n(extReset_n), .sleepRequest(sleepRequest),
        .flagClear(flagClear), .scratchWrite(scratchWrite), .scratchIndex(scratchIndex),
        .scratchData(scratchData), .lcdEnableIn(lcdEnableIn), .pinOutValue(pinOutValue),
        .pinOutEnable(pinOutEnable), .pullupEnableReg(pullupEnableReg),
        .wakeRequest(wakeRequest), .powerState(powerState), .flags(flags),
        .railSourceBit(railSourceBit), .powerMgmtVector(powerMgmtVector),
        .rtcVector(rtcVector), .coreResetToVector(coreResetToVector),
        .scratchRead(scratchRead), .lcdEnable(lcdEnable), .pinOut(pinOut), .pinOe(pinOe),
        .pullupOn(pullupOn));
    swe_soft_model swe_soft_model_inst (.ref_clk(ref_clk), .sleepCmd(sleepCmd), .flags(flags),
        .flagClear(flagClear), .sleepRequest(sleepRequest));

    // ============================================================
    // clock, pulse counter, helpers
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (coreResetToVector === 1'b1) vecCount++;

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic go_sleep();
        sleepCmd = 1'b1;
        cycles(1);
        sleepCmd = 1'b0;
        cycles(4);
    endtask
    task automatic arm(input int idx, input logic en);
        cfg.tempMeasureInSleep = 1'b1;
        cfg.tempWakeEnable = en && idx == 0;
        cfg.powerIrqEnableReg[swe_pkg::SUPPLY_SENSE_BIT] = en && idx == 1;
        cfg.rtcIntervalEnable = en && idx == 2;
        cfg.alarmFieldEnables = en && idx == 3;
        cfg.irqPinConfigReg[swe_pkg::IRQ_ZERO_SEL_BIT] = en && idx == 4;
        cfg.irqPinConfigReg[3:2] = (en && idx == 5) ? swe_pkg::IRQ_ONE_ON : 2'h0;
        cfg.rxWakeSelect = (en && idx == 6) ? swe_pkg::RX_WAKE_ON : 2'h0;
    endtask
    // pin sources use low-level wake, edge select left at 0
    task automatic fire(input int idx);
        case (idx)
            0: events.tempChange = 1'b1;
            1: events.supplySenseChange = 1'b1;
            2: events.rtcInterval = 1'b1;
            3: events.rtcAlarm = 1'b1;
            4: irq0 = 1'b0;
            5: irq1 = 1'b0;
            6: rxLine = ~rxLine;
            default: extReset_n = 1'b0;
        endcase
        cycles(1);
        events = '0;
        irq0 = 1'b1;
        irq1 = 1'b1;
        extReset_n = 1'b1;
    endtask
    task automatic wait_wake(output int n);
        for (n = 0; n < 8 && powerState === swe_pkg::SLEEP_STATE; n++) cycles(1);
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ============================================================
    // tests
    initial begin
        #20000;
        n_fail++;
        close_out();
    end
    initial begin
        cycles(2);
        rst_n = 1'b1;
        cycles(3);
        scratchIndex = 2'h2;
        scratchData = 8'hA5;
        scratchWrite = 1'b1;
        cycles(1);
        scratchWrite = 1'b0;
        for (int idx = 0; idx < 8; idx++) begin
            if (idx < 7) begin
                arm(idx, 1'b0);
                go_sleep();
                fire(idx);
                cycles(6);
                check("masked source", 8'(swe_pkg::SLEEP_STATE), 8'(powerState));
                check("masked wake request", 8'h00, 8'(wakeRequest));
            end
            arm(idx, 1'b1);
            go_sleep();
            check("sleep entered", 8'(swe_pkg::SLEEP_STATE), 8'(powerState));
            check("pins released", 8'h00, pinOe[7:0]);
            check("pull-ups", pullupEnableReg[7:0], pullupOn[7:0]);
            check("lcd in sleep", 8'h01, 8'(lcdEnable));
            check("pins low in sleep", 8'h00, pinOut[7:0]);
            v = vecCount;
            fire(idx);
            wait_wake(waitCycles);
            check("woke to battery run", 8'(swe_pkg::BATTERY_RUN_STATE), 8'(powerState));
            check("wake flags", WAKE_MASK[idx], 8'(flags));
            check("wake request", 8'(idx != 7), 8'(wakeRequest));
            check("pins driven again", 8'hFF, pinOe[7:0]);
            cycles(1);
            check("restart pulse", 8'(v + 1), 8'(vecCount));
            check("power vector", 8'(idx == 1), 8'(powerMgmtVector));
            check("rtc vector", 8'(idx == 2 || idx == 3), 8'(rtcVector));
            $display("test %0d done", idx);
        end
        check("scratch kept", 8'hA5, scratchRead);
        // falling-edge mode: a pin held low across sleep entry must not wake again
        arm(4, 1'b1);
        cfg.irqZeroEdgeSelect = 1'b1;
        irq0 = 1'b0;
        go_sleep();
        check("held pin in edge mode", 8'(swe_pkg::SLEEP_STATE), 8'(powerState));
        cfg.tempWakeEnable = 1'b1;
        cfg.tempMeasureInSleep = 1'b0;
        fire(0);
        cycles(2);
        check("temp off in sleep", 8'(swe_pkg::SLEEP_STATE), 8'(powerState));
        fire(4);
        wait_wake(waitCycles);
        check("edge wake", 8'(swe_pkg::BATTERY_RUN_STATE), 8'(powerState));
        $display("test edge mode done");
        go_sleep();
        // clock enable low freezes the restore until it returns
        clkEn = 1'b0;
        events.mainSupplyOk = 1'b1;
        cycles(3);
        check("frozen state", 8'(swe_pkg::SLEEP_STATE), 8'(powerState));
        check("frozen rail source", 8'h00, 8'(railSourceBit));
        clkEn = 1'b1;
        wait_wake(waitCycles);
        cycles(1);
        check("restore power vector", 8'h01, 8'(powerMgmtVector));
        check("restore wake request", 8'h01, 8'(wakeRequest));
        check("restored state", 8'(swe_pkg::NORMAL_RUN_STATE), 8'(powerState));
        check("restored flag", 8'h20, 8'(flags));
        check("rail source", 8'h01, 8'(railSourceBit));
        $display("test restore done");
        close_out();
    end
endmodule // tb
